/* File: restart_supervisor.sv */
// fault auto-restart supervisor with Avalon-MM register slave
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
module restart_supervisor #(
	parameter int unsigned TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic resetn,
	input supervisor_pkg::avl_req_t avl_req,
	output logic [31:0] avl_readdata,
	output logic avl_waitrequest,
	input supervisor_pkg::fault_in_t fault_in,
	input wire logic undervoltage,
	input wire logic start_cmd,
	input wire logic manual_dir_en,
	input wire logic decel_done,
	output supervisor_pkg::restart_cmd_t restart_cmd,
	output logic fault_msg,
	output logic [4:0] fault_code,
	output logic drive_inhibit,
	output logic irq
);
	import supervisor_pkg::*;

	typedef struct packed {
		sup_state_t state;
		restart_mode_t restart_behaviour_select;
		restart_mode_t mode_taken;
		logic [9:0] power_loss_tolerance_time;
		logic [9:0] restart_wait_time;
		logic [9:0] wait_cnt;
		logic [9:0] uv_cnt;
		logic uv_tripped;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic waitreq;
		logic [31:0] rdata;
		restart_cmd_t restart;
		logic fault_msg;
		logic [4:0] fault_code;
		logic inhibit;
		logic irq;
	} sup_st_t;

	sup_st_t s_q;
	sup_st_t s_d;
	logic tick;
	logic [NUM_CLASSES-1:0] attempt;
	logic [NUM_CLASSES-1:0] allow;
	logic [NUM_CLASSES-1:0][4:0] count;

	// merge write data into a register by byte lane
	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		end
		return r;
	endfunction : merge_be

	// keep a programmed time inside its legal range
	function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo,
		input logic [9:0] hi);
		logic [9:0] r;
		r = v;
		if (v < lo)
			r = lo;
		else if (v > hi)
			r = hi;
		return r;
	endfunction : clamp

	// shared 100 ms time base
	tick_gen #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clock(clock),
		.resetn(resetn),
		.tick(tick)
	);

	// one attempt window per fault class
	generate
		for (genvar c = 0; c < NUM_CLASSES; c++)
		begin : g_class
			attempt_window #(
				.LIMIT(CLASS_LIMIT[c])
			) u_win (
				.clock(clock),
				.resetn(resetn),
				.tick(tick),
				.attempt(attempt[c]),
				.count(count[c]),
				.allow(allow[c])
			);
		end
	endgenerate

	// next-state logic: bus slave, undervoltage timer, restart sequencer
	always_comb
	begin
		logic bus_req;
		logic do_write;
		logic clear_fault;
		logic [31:0] wmerged;
		logic [31:0] rmux;
		logic [2:0] ev;
		logic [2:0] w1c;
		logic uv_trip;
		logic ev_valid;
		logic [4:0] ev_code;
		logic [NUM_CLASSES-1:0] cls;
		logic qualifies;
		logic permitted;
		bus_req = 1'b0;
		do_write = 1'b0;
		clear_fault = 1'b0;
		wmerged = 32'h00000000;
		rmux = 32'h00000000;
		ev = 3'h0;
		w1c = 3'h0;
		uv_trip = 1'b0;
		ev_valid = 1'b0;
		ev_code = 5'h00;
		cls = '0;
		qualifies = 1'b0;
		permitted = 1'b0;
		attempt = '0;
		s_d = s_q;
		s_d.restart.pulse = 1'b0;

		// read mux
		unique case (avl_req.address)
			OFS_CTRL: rmux = {30'h00000000, s_q.restart_behaviour_select};
			OFS_TOL: rmux = {22'h000000, s_q.power_loss_tolerance_time};
			OFS_WAIT: rmux = {22'h000000, s_q.restart_wait_time};
			OFS_STATUS: rmux = {21'h000000, s_q.fault_code, s_q.mode_taken, s_q.state};
			OFS_IRQ_STAT: rmux = {29'h00000000, s_q.irq_stat};
			OFS_IRQ_MASK: rmux = {29'h00000000, s_q.irq_mask};
			OFS_ATTEMPTS: rmux = {11'h000, count[CLS_UV], 3'h0, count[CLS_OV], 3'h0,
				count[CLS_OC]};
			default: rmux = 32'h00000000;
		endcase

		// one wait cycle, then answer; writes land on the answering edge
		bus_req = avl_req.read || avl_req.write;
		if (bus_req && s_q.waitreq)
		begin
			s_d.waitreq = 1'b0;
			if (avl_req.read)
				s_d.rdata = rmux;
		end
		else if (!s_q.waitreq)
		begin
			s_d.waitreq = 1'b1;
			do_write = avl_req.write;
		end
		wmerged = merge_be(rmux, avl_req.writedata, avl_req.byteenable);
		if (do_write)
		begin
			unique case (avl_req.address)
				OFS_CTRL:
				begin
					s_d.restart_behaviour_select = restart_mode_t'(wmerged[1:0]);
					clear_fault = wmerged[CTRL_CLEAR_BIT];
				end
				OFS_TOL: s_d.power_loss_tolerance_time =
					clamp(wmerged[9:0], TOL_MIN, TOL_MAX);
				OFS_WAIT: s_d.restart_wait_time =
					clamp(wmerged[9:0], WAIT_MIN, WAIT_MAX);
				OFS_IRQ_STAT: w1c = wmerged[2:0];
				OFS_IRQ_MASK: s_d.irq_mask = wmerged[2:0];
				default: ;
			endcase
		end

		// mains dip: count while low voltage lasts, trip once when tolerance ends
		if (!undervoltage)
		begin
			s_d.uv_cnt = 10'h000;
			s_d.uv_tripped = 1'b0;
		end
		else
		begin
			if (s_q.uv_cnt == 10'h000 && !s_q.uv_tripped)
				ev[IRQ_UV] = 1'b1;
			if (tick && s_q.uv_cnt < s_q.power_loss_tolerance_time)
				s_d.uv_cnt = s_q.uv_cnt + 10'h001;
			if (s_q.uv_cnt >= s_q.power_loss_tolerance_time && !s_q.uv_tripped)
			begin
				uv_trip = 1'b1;
				s_d.uv_tripped = 1'b1;
			end
		end

		// fault decode into classes
		ev_valid = fault_in.valid || uv_trip;
		ev_code = fault_in.valid ? fault_in.code : CODE_UV;
		cls[CLS_OC] = ev_code >= CODE_OC_FIRST && ev_code <= CODE_OC_LAST;
		cls[CLS_OV] = ev_code == CODE_OV_A || ev_code == CODE_OV_B;
		cls[CLS_UV] = ev_code == CODE_UV;
		qualifies = |cls;
		permitted = |(cls & allow);

		// restart sequencer
		unique case (s_q.state)
			ST_IDLE:
			begin
				if (ev_valid)
				begin
					s_d.fault_code = ev_code;
					s_d.inhibit = 1'b1;
					if (s_q.restart_behaviour_select == alarm_only_mode || !qualifies
						|| !permitted)
					begin
						s_d.state = ST_FAULT;
						s_d.fault_msg = 1'b1;
						ev[IRQ_FAULT] = 1'b1;
					end
					else
					begin
						attempt = cls;
						s_d.state = ST_WAIT;
						s_d.mode_taken = s_q.restart_behaviour_select;
						s_d.wait_cnt = s_q.restart_wait_time;
					end
				end
			end
			ST_WAIT:
			begin
				if (tick && s_q.wait_cnt != 10'h000)
					s_d.wait_cnt = s_q.wait_cnt - 10'h001;
				if (s_q.wait_cnt == 10'h000 && (start_cmd || manual_dir_en))
				begin
					s_d.restart.pulse = 1'b1;
					s_d.restart.kind = s_q.mode_taken;
					s_d.inhibit = 1'b0;
					ev[IRQ_RESTART] = 1'b1;
					if (s_q.mode_taken == sync_brake_then_fault_mode)
						s_d.state = ST_DECEL;
					else
						s_d.state = ST_IDLE;
				end
			end
			ST_DECEL:
			begin
				if (decel_done)
				begin
					s_d.state = ST_FAULT;
					s_d.fault_msg = 1'b1;
					s_d.inhibit = 1'b1;
					ev[IRQ_FAULT] = 1'b1;
				end
			end
			ST_FAULT:
			begin
				if (clear_fault)
				begin
					s_d.state = ST_IDLE;
					s_d.fault_msg = 1'b0;
					s_d.inhibit = 1'b0;
				end
			end
		endcase

		// sticky status: a new event beats a clear in the same cycle
		s_d.irq_stat = ev | (s_q.irq_stat & ~w1c);
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
	end

	// state register
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			s_q <= '0;
			s_q.state <= ST_IDLE;
			s_q.restart_behaviour_select <= alarm_only_mode;
			s_q.mode_taken <= alarm_only_mode;
			s_q.power_loss_tolerance_time <= TOL_RESET;
			s_q.restart_wait_time <= WAIT_RESET;
			s_q.irq_mask <= IRQ_MASK_RESET;
			s_q.waitreq <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// outputs straight from the state register
	assign avl_readdata = s_q.rdata;
	assign avl_waitrequest = s_q.waitreq;
	assign restart_cmd = s_q.restart;
	assign fault_msg = s_q.fault_msg;
	assign fault_code = s_q.fault_code;
	assign drive_inhibit = s_q.inhibit;
	assign irq = s_q.irq;
endmodule : restart_supervisor

/* File: supervisor_pkg.sv */
// constants, types and register map of the fault auto-restart supervisor
package supervisor_pkg;

	// time base
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_PERIOD_MS = 100;
	localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int WINDOW_MINUTES = 10;
	localparam logic [12:0] WINDOW_TICKS = 13'(WINDOW_MINUTES * 60 * 1000 / TICK_PERIOD_MS);

	// programmable times, in ticks of 0.1 s
	localparam logic [9:0] TOL_MIN = 10'h003;
	localparam logic [9:0] TOL_MAX = 10'h0FA;
	localparam logic [9:0] TOL_RESET = 10'h032;
	localparam logic [9:0] WAIT_MIN = 10'h003;
	localparam logic [9:0] WAIT_MAX = 10'h3E8;
	localparam logic [9:0] WAIT_RESET = 10'h00A;

	// fault codes and attempt limits per class
	localparam logic [4:0] CODE_OC_FIRST = 5'h01;
	localparam logic [4:0] CODE_OC_LAST = 5'h04;
	localparam logic [4:0] CODE_OV_A = 5'h07;
	localparam logic [4:0] CODE_OV_B = 5'h0F;
	localparam logic [4:0] CODE_UV = 5'h09;
	localparam int NUM_CLASSES = 3;
	localparam int CLS_OC = 0;
	localparam int CLS_OV = 1;
	localparam int CLS_UV = 2;
	localparam logic [4:0] LIMIT_OC = 5'h04;
	localparam logic [4:0] LIMIT_OV = 5'h03;
	localparam logic [4:0] LIMIT_UV = 5'h10;
	localparam logic [2:0][4:0] CLASS_LIMIT = {LIMIT_UV, LIMIT_OV, LIMIT_OC};

	// register byte offsets and fields
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_TOL = 5'h04;
	localparam logic [4:0] OFS_WAIT = 5'h08;
	localparam logic [4:0] OFS_STATUS = 5'h0C;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
	localparam logic [4:0] OFS_ATTEMPTS = 5'h18;
	localparam int CTRL_CLEAR_BIT = 4;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_RESTART = 1;
	localparam int IRQ_UV = 2;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	typedef enum logic [1:0] {
		alarm_only_mode = 2'h0,
		restart_from_start_freq_mode = 2'h1,
		sync_accel_mode = 2'h2,
		sync_brake_then_fault_mode = 2'h3
	} restart_mode_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_DECEL = 4'h4,
		ST_FAULT = 4'h8
	} sup_state_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} avl_req_t;

	typedef struct packed {
		logic valid;
		logic [4:0] code;
	} fault_in_t;

	typedef struct packed {
		logic pulse;
		restart_mode_t kind;
	} restart_cmd_t;

endpackage : supervisor_pkg

/* File: tick_gen.sv */
// fixed time base: one-cycle tick every CYCLES clocks
`timescale 1ns/1ns
module tick_gen #(
	parameter int unsigned CYCLES = supervisor_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic resetn,
	output logic tick
);
	import supervisor_pkg::*;

	typedef struct packed {
		logic [21:0] cnt;
		logic tick;
	} tick_st_t;

	tick_st_t s_q;
	tick_st_t s_d;

	// divider wraps at CYCLES-1
	always_comb
	begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt == 22'(CYCLES - 1))
		begin
			s_d.cnt = 22'h000000;
			s_d.tick = 1'b1;
		end
		else
			s_d.cnt = s_q.cnt + 22'h000001;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick = s_q.tick;
endmodule : tick_gen

/* File: attempt_window.sv */
// per-class restart attempt counter with ten-minute window
`timescale 1ns/1ns
module attempt_window #(
	parameter logic [4:0] LIMIT = supervisor_pkg::LIMIT_OC
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic tick,
	input wire logic attempt,
	output logic [4:0] count,
	output logic allow
);
	import supervisor_pkg::*;

	typedef struct packed {
		logic [4:0] count;
		logic [12:0] timer;
	} win_st_t;

	win_st_t s_q;
	win_st_t s_d;

	// window runs from the first attempt, then forgets all attempts
	always_comb
	begin
		s_d = s_q;
		if (s_q.count != 5'h00 && tick)
		begin
			if (s_q.timer + 13'h0001 >= WINDOW_TICKS)
			begin
				s_d.count = 5'h00;
				s_d.timer = 13'h0000;
			end
			else
				s_d.timer = s_q.timer + 13'h0001;
		end
		if (attempt && s_q.count < LIMIT)
		begin
			if (s_q.count == 5'h00)
				s_d.timer = 13'h0000;
			s_d.count = s_d.count + 5'h01;
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign count = s_q.count;
	assign allow = (s_q.count < LIMIT);
endmodule : attempt_window

/* File: restart_supervisor_checker.sv */
// concurrent checks on the restart supervisor ports
`timescale 1ns/1ns
module restart_supervisor_checker #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic clock,
	input wire logic resetn,
	input supervisor_pkg::avl_req_t avl_req,
	input wire logic avl_waitrequest,
	input supervisor_pkg::fault_in_t fault_in,
	input wire logic start_cmd,
	input wire logic manual_dir_en,
	input wire logic decel_done,
	input supervisor_pkg::restart_cmd_t restart_cmd,
	input wire logic fault_msg,
	input wire logic [4:0] fault_code,
	input wire logic drive_inhibit
);
	import supervisor_pkg::*;
	logic decel_q;
	logic idle;
	// tracks the catch-and-brake phase
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			decel_q <= 1'h0;
		else if (restart_cmd.pulse && restart_cmd.kind == sync_brake_then_fault_mode)
			decel_q <= 1'h1;
		else if (fault_msg)
			decel_q <= 1'h0;
	end
	// only an idle supervisor takes a fault
	assign idle = !drive_inhibit && !fault_msg && !decel_q && !restart_cmd.pulse;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	sequence s_ack;
		!avl_waitrequest ##1 avl_waitrequest;
	endsequence
	sequence s_pulse_end;
		!drive_inhibit ##1 !restart_cmd.pulse;
	endsequence
	property p_bus_ack;
		(avl_req.read || avl_req.write) && avl_waitrequest |=> s_ack;
	endproperty
	property p_entry;
		fault_in.valid && idle |=> (fault_msg || drive_inhibit) && fault_code == $past(fault_in.code);
	endproperty
	property p_pulse_start;
		restart_cmd.pulse |-> $past(start_cmd || manual_dir_en);
	endproperty
	property p_pulse_waited;
		restart_cmd.pulse |-> $past(drive_inhibit, 2 * TICK_CYCLES);
	endproperty
	property p_pulse_kind;
		restart_cmd.pulse |-> restart_cmd.kind != alarm_only_mode;
	endproperty
	property p_pulse_once;
		restart_cmd.pulse |-> s_pulse_end;
	endproperty
	property p_decel;
		decel_q && decel_done |-> ##[1:2] fault_msg;
	endproperty
	property p_msg_stays;
		fault_msg && !(avl_req.write && !avl_waitrequest) |=> fault_msg;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("bus access not answered in one cycle");
	a_entry: assert property (p_entry) else $error("fault not taken in idle");
	a_pulse_start: assert property (p_pulse_start) else $error("restart without start");
	a_pulse_waited: assert property (p_pulse_waited) else $error("restart too early");
	a_pulse_kind: assert property (p_pulse_kind) else $error("restart in alarm mode");
	a_pulse_once: assert property (p_pulse_once) else $error("restart pulse malformed");
	a_decel: assert property (p_decel) else $error("no fault after braking");
	a_msg_stays: assert property (p_msg_stays) else $error("fault message dropped");
endmodule : restart_supervisor_checker

bind restart_supervisor restart_supervisor_checker #(
	.TICK_CYCLES(TICK_CYCLES)
) u_checker (
	.clock(clock),
	.resetn(resetn),
	.avl_req(avl_req),
	.avl_waitrequest(avl_waitrequest),
	.fault_in(fault_in),
	.start_cmd(start_cmd),
	.manual_dir_en(manual_dir_en),
	.decel_done(decel_done),
	.restart_cmd(restart_cmd),
	.fault_msg(fault_msg),
	.fault_code(fault_code),
	.drive_inhibit(drive_inhibit)
);

/* File: fault_source_model.sv */
// power stage and start source facing the supervisor
`timescale 1ns/1ns
module fault_source_model (
	input wire logic clock,
	input supervisor_pkg::restart_cmd_t restart_cmd,
	output supervisor_pkg::fault_in_t fault_in,
	output logic undervoltage,
	output logic start_cmd,
	output logic manual_dir_en,
	output logic decel_done
);
	import supervisor_pkg::*;
	int decel_cycles = 5;
	int dcnt = 0;
	// quiet power stage, no start held
	initial
	begin
		fault_in = '0;
		undervoltage = 1'h0;
		start_cmd = 1'h0;
		manual_dir_en = 1'h0;
	end
	// one-cycle fault report, code then scrambled
	task automatic fault(input logic [4:0] code);
		fault_in <= '{1'h1, code};
		@(posedge clock);
		fault_in <= '{1'h0, ~code};
	endtask : fault
	// braking ends some cycles after a catch-and-brake restart
	always @(posedge clock)
	begin
		if (restart_cmd.pulse && restart_cmd.kind == sync_brake_then_fault_mode)
			dcnt <= decel_cycles;
		else if (dcnt > 0)
			dcnt <= dcnt - 1;
		decel_done <= (dcnt == 1);
	end
endmodule : fault_source_model

/* File: fault_auto_restart_supervisor_tb_top.sv */
// self-checking bench for the restart supervisor
`timescale 1ns/1ns
module fault_auto_restart_supervisor_tb_top;
	import supervisor_pkg::*;
	localparam int TC = 4;
	logic clock = 1'h0;
	logic resetn = 1'h0;
	avl_req_t avl_req = '0;
	logic [31:0] avl_readdata, rd_q;
	logic avl_waitrequest, decel_done, undervoltage, start_cmd, manual_dir_en;
	fault_in_t fault_in;
	restart_cmd_t restart_cmd;
	logic fault_msg, drive_inhibit, irq, got;
	logic [4:0] fault_code;
	int n_mismatch = 0;
	int check_count = 0;
	int c;
	restart_supervisor #(
		.TICK_CYCLES(TC)
	) u_restart_supervisor (
		.clock(clock),
		.resetn(resetn),
		.avl_req(avl_req),
		.avl_readdata(avl_readdata),
		.avl_waitrequest(avl_waitrequest),
		.fault_in(fault_in),
		.undervoltage(undervoltage),
		.start_cmd(start_cmd),
		.manual_dir_en(manual_dir_en),
		.decel_done(decel_done),
		.restart_cmd(restart_cmd),
		.fault_msg(fault_msg),
		.fault_code(fault_code),
		.drive_inhibit(drive_inhibit),
		.irq(irq)
	);
	fault_source_model u_fault_source_model (
		.clock(clock),
		.restart_cmd(restart_cmd),
		.fault_in(fault_in),
		.undervoltage(undervoltage),
		.start_cmd(start_cmd),
		.manual_dir_en(manual_dir_en),
		.decel_done(decel_done)
	);
	// free-running clock
	initial
	begin
		forever #25 clock = ~clock;
	end
	task summarize;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			n_mismatch++;
		end
	endtask : chk
	task limit(input int k);
		if (k >= 400)
		begin
			n_mismatch++;
			summarize();
		end
	endtask : limit
	// attempt allowance of a fault code's class, zero where no restart is allowed
	function automatic logic [4:0] cls_limit(input logic [4:0] code);
		if (code >= CODE_OC_FIRST && code <= CODE_OC_LAST)
			return LIMIT_OC;
		else if (code == CODE_OV_A || code == CODE_OV_B)
			return LIMIT_OV;
		else if (code == CODE_UV)
			return LIMIT_UV;
		return 5'h00;
	endfunction : cls_limit
	// one access, held until waitrequest is seen low
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avl_req <= '{~w, w, a, d, 4'hF};
		do @(posedge clock); while (avl_waitrequest !== 1'h0 && ++n < 400);
		limit(n);
		rd_q = avl_readdata;
		avl_req <= '0;
		@(posedge clock);
	endtask : bus
	// wait for a restart pulse or a fault message
	task wait_out;
		c = 0;
		do @(negedge clock); while (!restart_cmd.pulse && !fault_msg && ++c < 400);
		limit(c);
		got = restart_cmd.pulse;
		@(posedge clock);
	endtask : wait_out
	task run(input logic [4:0] code, input logic [1:0] mode);
		bus(1'h1, OFS_CTRL, {27'h0, 1'h1, 2'h0, mode});
		u_fault_source_model.fault(code);
		wait_out();
	endtask : run
	logic [4:0] ofs [6] = '{OFS_CTRL, OFS_TOL, OFS_WAIT, OFS_STATUS, OFS_IRQ_MASK, 5'h1C};
	logic [31:0] rst [6] = '{32'h0, 32'h32, 32'hA, 32'h1, 32'h0, 32'h0};
	// main sequence
	initial
	begin
		void'($urandom(32'h369869F5));
		repeat (3) @(posedge clock);
		resetn <= 1'h1;
		@(posedge clock);
		for (int i = 0; i < 6; i++)
		begin
			bus(1'h0, ofs[i], 32'h0);
			chk(rd_q, rst[i]);
		end
		bus(1'h1, OFS_IRQ_MASK, 32'h1);
		u_fault_source_model.start_cmd <= 1'h1;
		run(5'h01, 2'h0);
		chk({got, fault_msg, fault_code}, 7'h21);
		bus(1'h0, OFS_IRQ_STAT, 32'h0);
		chk({rd_q[0], irq}, 2'h3);
		bus(1'h1, OFS_IRQ_STAT, 32'h1);
		bus(1'h0, OFS_IRQ_STAT, 32'h0);
		chk(irq, 1'h0);
		bus(1'h1, OFS_WAIT, 32'h1);
		bus(1'h0, OFS_WAIT, 32'h0);
		chk(rd_q, 32'h3);
		for (int m = 1; m < 4; m++)
		begin
			u_fault_source_model.decel_cycles = 1 + $urandom % 30;
			run(CODE_OC_FIRST + 5'($urandom % 4), 2'(m));
			chk({got, restart_cmd.kind}, {1'h1, 2'(m)});
			chk(c >= 2 * TC + 2 && c <= 3 * TC + 1, 1'h1);
			if (m == 3)
				wait_out();
			chk(fault_msg, m == 3);
		end
		run(CODE_OC_LAST, 2'h1);
		chk(got, 1'h1);
		run(5'h02, 2'h1);
		chk({got, fault_msg}, 2'h1);
		run(5'h05, 2'h1);
		chk({got, fault_msg, fault_code}, 7'h25);
		bus(1'h0, OFS_ATTEMPTS, 32'h0);
		chk(rd_q[4:0], cls_limit(CODE_OC_LAST));
		u_fault_source_model.start_cmd <= 1'h0;
		bus(1'h1, OFS_CTRL, 32'h11);
		u_fault_source_model.fault(CODE_OV_A);
		repeat (100) @(posedge clock);
		chk(drive_inhibit, 1'h1);
		u_fault_source_model.manual_dir_en <= 1'h1;
		wait_out();
		chk(got, 1'h1);
		for (int i = 0; i < 3; i++)
		begin
			run(($urandom % 2) ? CODE_OV_A : CODE_OV_B, 2'h1);
			chk(got, (i + 1) < cls_limit(CODE_OV_B));
		end
		bus(1'h1, OFS_TOL, 32'h0);
		bus(1'h0, OFS_TOL, 32'h0);
		chk(rd_q, 32'h3);
		bus(1'h1, OFS_CTRL, 32'h11);
		u_fault_source_model.undervoltage <= 1'h1;
		repeat (2 * TC) @(negedge clock);
		chk(drive_inhibit, 1'h0);
		repeat (2 * TC + 2) @(negedge clock);
		chk(drive_inhibit, 1'h1);
		@(posedge clock);
		u_fault_source_model.undervoltage <= 1'h0;
		wait_out();
		chk(got, 1'h1);
		bus(1'h0, OFS_ATTEMPTS, 32'h0);
		chk(rd_q[20:16], 5'h01);
		bus(1'h0, OFS_IRQ_STAT, 32'h0);
		chk(rd_q[2], 1'h1);
		// let every class window run out, all attempt counts forgotten
		repeat (int'(WINDOW_TICKS) * TC) @(posedge clock);
		bus(1'h0, OFS_ATTEMPTS, 32'h0);
		chk(rd_q, 32'h0);
		summarize();
	end
endmodule : fault_auto_restart_supervisor_tb_top
